// ==== atr_defines.vh ====
`ifndef ATR_DEFINES_VH
`define ATR_DEFINES_VH

// Register byte offsets on the APB bus (one aligned word each).
`define ATR_MAP3_OFF 12'h00C
`define ATR_MAP_STEP 4
`define ATR_STATUS_OFF 12'h040
`define ATR_ADDR_W 12

// Selector word layout.
`define ATR_GATE_BIT 7
`define ATR_PICK_MSB 2
`define ATR_PICK_LSB 0
`define ATR_MAP_RESET 32'h00000000

// Program codes: 000 to 101 name programs 0 to 5, 110 and 111 are reserved.
`define ATR_PROG_LAST 3'h5
`define ATR_PROG_W 3

// Each program runs four conversions into result slots 0 to 3.
`define ATR_SLOT_W 2
`define ATR_SLOT_LAST 2'h3
`define ATR_SLOT_FIRST 2'h0

// Selectors 3 to 9 of the bank.
`define ATR_SEL_COUNT 7

// Status word layout.
`define ATR_STAT_BUSY 0
`define ATR_STAT_PROG_LSB 4
`define ATR_STAT_SLOT_LSB 8
`define ATR_STAT_PEND_LSB 16
`define ATR_STAT_RSVD_BIT 24

`endif

// ==== atr_selector.v ====
`timescale 1ns/1ps
`include "atr_defines.vh"
// One trigger selector: its gate bit, its program pick and a pending
// launch that waits for the sequencer to take it.
module atr_selector #(
  parameter [11:0] OFFSET = 12'h000
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  input wire pclken,
  // Register write port
  input wire wr_en,
  input wire [11:0] wr_addr,
  input wire [31:0] wr_data,
  // Trigger and arbitration
  input wire start_in,
  input wire grant,
  // State
  output wire [31:0] map_word,
  output wire pending,
  output wire [2:0] pend_prog,
  output wire reserved_hit
);

  reg gate_reg;
  reg [2:0] pick_reg;
  reg pend_reg;
  reg [2:0] pend_prog_reg;
  wire pick_valid;
  wire accept;

  assign pick_valid = (pick_reg <= `ATR_PROG_LAST);
  // A reserved pick starts nothing and leaves the results alone.
  assign accept = start_in & gate_reg & pick_valid;
  assign reserved_hit = start_in & gate_reg & ~pick_valid;

  assign map_word = {24'h000000, gate_reg, 4'h0, pick_reg};
  assign pending = pend_reg;
  assign pend_prog = pend_prog_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_reg <= 1'b0;
      pick_reg <= 3'h0;
    end else if (pclken && wr_en && wr_addr == OFFSET) begin
      gate_reg <= wr_data[`ATR_GATE_BIT];
      pick_reg <= wr_data[`ATR_PICK_MSB:`ATR_PICK_LSB];
    end
  end

  // The pick is captured with the trigger, so a rewrite while the launch
  // waits does not change which program it runs. A new trigger in the
  // cycle of the grant wins and stays pending.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg <= 1'b0;
      pend_prog_reg <= 3'h0;
    end else if (pclken) begin
      if (accept) begin
        pend_reg <= 1'b1;
        pend_prog_reg <= pick_reg;
      end else if (grant) begin
        pend_reg <= 1'b0;
      end
    end
  end

endmodule // atr_selector

// ==== atr_trigger_router.v ====
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "atr_defines.vh"

module atr_trigger_router (
  // Clock, reset and clock enable
  input wire pclk,
  input wire presetn,
  input wire pclken,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // Start triggers from the motor PWM drivers
  input wire driver_a_start_3,
  input wire driver_a_start_4,
  input wire driver_a_start_5,
  input wire driver_b_start_0,
  input wire driver_b_start_1,
  input wire driver_b_start_2,
  input wire driver_b_start_3,
  // Conversion sequencer
  output reg conv_req,
  output reg [2:0] conv_prog,
  output reg [1:0] conv_slot,
  input wire conv_ack,
  output reg prog_done
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  wire [`ATR_SEL_COUNT-1:0] start_vec;
  wire [`ATR_SEL_COUNT-1:0] pend_vec;
  wire [`ATR_SEL_COUNT-1:0] rsvd_vec;
  reg [`ATR_SEL_COUNT-1:0] grant_vec;
  wire [31:0] map_words [0:`ATR_SEL_COUNT-1];
  wire [2:0] pend_progs [0:`ATR_SEL_COUNT-1];

  reg state_reg;
  reg state_next;
  reg [2:0] prog_next;
  reg [1:0] slot_next;
  reg req_next;
  reg done_next;
  reg rsvd_seen_reg;

  wire apb_setup;
  wire apb_write;
  wire status_hit;
  wire map_hit;
  reg [31:0] rd_mux;
  reg map_sel_hit;
  reg any_pend;
  reg [2:0] pick_prog;
  integer k;

  // Slot i of the vector is selector i+3.
  assign start_vec = {driver_b_start_3, driver_b_start_2,
                      driver_b_start_1, driver_b_start_0,
                      driver_a_start_5, driver_a_start_4,
                      driver_a_start_3};

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pwrite;

  genvar g;
  generate
    for (g = 0; g < `ATR_SEL_COUNT; g = g + 1) begin : gen_sel
      localparam [31:0] OFF_W = `ATR_MAP3_OFF + g * `ATR_MAP_STEP;
      atr_selector #(
        .OFFSET(OFF_W[11:0])
      ) u_sel (
        .pclk(pclk),
        .presetn(presetn),
        .pclken(pclken),
        .wr_en(apb_write),
        .wr_addr(paddr),
        .wr_data(pwdata),
        .start_in(start_vec[g]),
        .grant(grant_vec[g]),
        .map_word(map_words[g]),
        .pending(pend_vec[g]),
        .pend_prog(pend_progs[g]),
        .reserved_hit(rsvd_vec[g])
      );
    end
  endgenerate

  // Fixed priority: the lowest selector number is served first. The
  // sequencer runs one program at a time, so later triggers wait pending.
  always @* begin
    grant_vec = {`ATR_SEL_COUNT{1'b0}};
    any_pend = 1'b0;
    pick_prog = 3'h0;
    for (k = 0; k < `ATR_SEL_COUNT; k = k + 1) begin
      if (pend_vec[k] && !any_pend) begin
        any_pend = 1'b1;
        pick_prog = pend_progs[k];
        if (state_reg == ST_IDLE) begin
          grant_vec[k] = 1'b1;
        end
      end
    end
  end

  // Program sequencer: four requests, one per result slot.
  always @* begin
    state_next = state_reg;
    prog_next = conv_prog;
    slot_next = conv_slot;
    req_next = conv_req;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (any_pend) begin
          prog_next = pick_prog;
          slot_next = `ATR_SLOT_FIRST;
          req_next = 1'b1;
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_ack) begin
          if (conv_slot == `ATR_SLOT_LAST) begin
            req_next = 1'b0;
            done_next = 1'b1;
            state_next = ST_IDLE;
          end else begin
            slot_next = conv_slot + 2'h1;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        req_next = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      conv_prog <= 3'h0;
      conv_slot <= 2'h0;
      conv_req <= 1'b0;
      prog_done <= 1'b0;
    end else if (pclken) begin
      state_reg <= state_next;
      conv_prog <= prog_next;
      conv_slot <= slot_next;
      conv_req <= req_next;
      prog_done <= done_next;
    end
  end

  // Sticky flag for triggers dropped on a reserved code; write 1 clears,
  // and a new drop in the same cycle keeps it set.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsvd_seen_reg <= 1'b0;
    end else if (pclken) begin
      if (|rsvd_vec) begin
        rsvd_seen_reg <= 1'b1;
      end else if (apb_write && status_hit &&
                   pwdata[`ATR_STAT_RSVD_BIT]) begin
        rsvd_seen_reg <= 1'b0;
      end
    end
  end

  // APB decode. Read data is latched in the setup cycle so the access
  // phase completes with no wait state.
  assign status_hit = (paddr == `ATR_STATUS_OFF);

  always @* begin
    rd_mux = 32'h00000000;
    map_sel_hit = 1'b0;
    for (k = 0; k < `ATR_SEL_COUNT; k = k + 1) begin
      if (paddr == `ATR_MAP3_OFF + k * `ATR_MAP_STEP) begin
        rd_mux = map_words[k];
        map_sel_hit = 1'b1;
      end
    end
    if (status_hit) begin
      rd_mux[`ATR_STAT_BUSY] = (state_reg == ST_CONV);
      rd_mux[`ATR_STAT_PROG_LSB +: 3] = conv_prog;
      rd_mux[`ATR_STAT_SLOT_LSB +: 2] = conv_slot;
      rd_mux[`ATR_STAT_PEND_LSB +: `ATR_SEL_COUNT] = pend_vec;
      rd_mux[`ATR_STAT_RSVD_BIT] = rsvd_seen_reg;
    end
  end

  assign map_hit = map_sel_hit;
  assign pready = 1'b1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (pclken) begin
      if (apb_setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= ~(map_hit | status_hit);
      end
    end
  end

endmodule // atr_trigger_router

// ==== atr_trigger_router_chk.sv ====
`timescale 1ns/1ps
module atr_trigger_router_chk (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bus and sequencer
  input wire pready,
  input wire conv_req,
  input wire [2:0] conv_prog,
  input wire [1:0] conv_slot,
  input wire conv_ack,
  input wire prog_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire step = conv_req && conv_ack;
  zero_wait_a: assert property (pready)
    else $error("pready low");
  launch_slot_a: assert property (
    $rose(conv_req) |-> conv_slot == 2'h0) else $error("launch slot");
  prog_legal_a: assert property (
    conv_req |-> conv_prog <= 3'h5) else $error("bad program");
  slot_step_a: assert property (step && conv_slot != 2'h3 |=>
    conv_req && conv_slot == $past(conv_slot) + 2'h1) else $error("slot step");
  slot_hold_a: assert property (conv_req && !conv_ack |=>
    conv_slot == $past(conv_slot)) else $error("slot moved");
  last_done_a: assert property (step && conv_slot == 2'h3 |=>
    !conv_req && prog_done) else $error("no done");
  done_pulse_a: assert property (prog_done |=> !prog_done)
    else $error("done width");
  prog_hold_a: assert property (
    conv_req |=> !conv_req || $stable(conv_prog))
    else $error("program moved");
  cover property ($rose(conv_req));
  cover property (prog_done);
  cover property ($rose(conv_req) && conv_prog == 3'h5);
endmodule // atr_trigger_router_chk

bind atr_trigger_router atr_trigger_router_chk u_chk (.pclk(pclk),
  .presetn(presetn), .pready(pready), .conv_req(conv_req),
  .conv_prog(conv_prog), .conv_slot(conv_slot), .conv_ack(conv_ack),
  .prog_done(prog_done));

// ==== atr_seq_model.sv ====
`timescale 1ns/1ps
// Sequencer: takes each conversion after slow idle cycles.
module atr_seq_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Requests
  input wire conv_req,
  input wire [1:0] slow,
  output reg conv_ack
);
  reg [1:0] wait_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_ack <= 1'b0;
      wait_reg <= 2'h0;
    end else if (conv_ack || !conv_req) begin
      // A gap after each accept lets the slot move on first.
      conv_ack <= 1'b0;
      wait_reg <= slow;
    end else if (wait_reg == 2'h0) begin
      conv_ack <= 1'b1;
    end else begin
      wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule // atr_seq_model

// ==== atr_trigger_router_tb.sv ====
`timescale 1ns/1ps
`include "atr_defines.vh"
module atr_trigger_router_tb;
  reg pclk, presetn, psel, penable, pwrite, er;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd, w;
  reg [31:0] mdl [0:6];
  reg [2:0] q [$];
  reg [6:0] trg;
  reg [1:0] slow;
  wire [31:0] prdata;
  wire pready, pslverr, conv_req, conv_ack, prog_done;
  wire [2:0] conv_prog;
  wire [1:0] conv_slot;
  integer err_count, checks, seed, i, j, k;
  atr_trigger_router dut (.pclk(pclk), .presetn(presetn), .pclken(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .driver_a_start_3(trg[0]), .driver_a_start_4(trg[1]),
    .driver_a_start_5(trg[2]), .driver_b_start_0(trg[3]),
    .driver_b_start_1(trg[4]), .driver_b_start_2(trg[5]),
    .driver_b_start_3(trg[6]), .conv_req(conv_req), .conv_prog(conv_prog),
    .conv_slot(conv_slot), .conv_ack(conv_ack), .prog_done(prog_done));
  atr_seq_model seq (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
    .slow(slow), .conv_ack(conv_ack));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  function [11:0] ad(input integer n);
    ad = `ATR_MAP3_OFF + {n[9:0], 2'b00};
  endfunction
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks = checks + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task apb(input [11:0] a, input wr, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task fire(input [6:0] m);
    begin
      @(posedge pclk);
      trg <= m;
      @(posedge pclk);
      trg <= 7'h00;
    end
  endtask
  task run(input [2:0] c);
    begin
      for (k = 0; k < 50 && conv_req !== 1'b1; k = k + 1)
        @(negedge pclk);
      chk({conv_req, conv_prog}, {1'b1, c});
      for (k = 0; k < 50 && prog_done !== 1'b1; k = k + 1)
        @(negedge pclk);
      chk(prog_done, 1'b1);
    end
  endtask
  task end_sim;
    begin
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    #200000;
    err_count = err_count + 1;
    end_sim;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, trg, slow} = 0;
    {err_count, checks} = 0;
    seed = 72050;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      apb(ad(i), 1'b0, 32'h0);
      chk(rd, `ATR_MAP_RESET);
      mdl[i] = $random(seed);
      apb(ad(i), 1'b1, mdl[i]);
      apb(ad(i), 1'b0, 32'h0);
      chk(rd, mdl[i] & 32'h87);
      chk(er, 1'b0);
    end
    apb(12'h000, 1'b0, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h00000000);
    $display("register test done");
    for (i = 0; i < 7; i = i + 1) begin
      mdl[i] = 32'h80 | (($random(seed) & 32'h7FFFFFFF) % 6);
      apb(ad(i), 1'b1, mdl[i] | 32'hFF70);
      slow <= i[1:0];
      fire(7'h01 << i);
      run(mdl[i][2:0]);
      q.push_back(mdl[i][2:0]);
    end
    fire(7'h7F);
    while (q.size() > 0)
      run(q.pop_front());
    $display("trigger test done");
    for (j = 0; j < 3; j = j + 1) begin
      w = (j == 0) ? 32'h05 : 32'h85 + j;
      apb(ad(3 * j), 1'b1, w);
      fire(7'h01 << (3 * j));
      repeat (8) begin
        @(negedge pclk);
        chk(conv_req, 1'b0);
      end
      // Only a reserved code may raise the sticky drop flag.
      apb(`ATR_STATUS_OFF, 1'b0, 32'h0);
      w = {rd[`ATR_STAT_PEND_LSB +: `ATR_SEL_COUNT], rd[`ATR_STAT_BUSY],
        rd[`ATR_STAT_RSVD_BIT]};
      chk(w, {8'h00, (j != 0)});
    end
    apb(`ATR_STATUS_OFF, 1'b1, 32'h1 << `ATR_STAT_RSVD_BIT);
    apb(`ATR_STATUS_OFF, 1'b0, 32'h0);
    chk({er, rd[`ATR_STAT_RSVD_BIT]}, 2'b00);
    $display("blocking test done");
    end_sim;
  end
endmodule // atr_trigger_router_tb
